// >>> pcd_pkg.sv
// Operation
// - Up mode counts from zero, one per tick
// - Down mode starts at upper limit, decrements
// - Reset pin low holds count at start
// - Count kept in non-volatile store, restored
// - Three input conditioning choices: logic, pull-up, pull-down
// - Edge select picks rising or falling edge
// - Prescaler forwards only every Nth edge
// - Configurable upper count limit in prescaled pulses
// - Display high value and decimal point shown
// - Limit off: count may exceed upper limit
// - Error mode flags above limit or below zero
// - Clamp mode shows limit value or zero
// - Menu steps in fixed order to output menu
// - Interface mode shows bus value, stops counting
// - Switching uses the displayed bus value
// - Bus address settable, limited to 0..239
// - Bus system initialisation resets the address
package pcd_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_PRESCALE = 8'h04;
    localparam logic [7:0] OFF_UPPER    = 8'h08;
    localparam logic [7:0] OFF_DISP_HI  = 8'h0c;
    localparam logic [7:0] OFF_ADDR     = 8'h10;
    localparam logic [7:0] OFF_COUNT    = 8'h14;
    localparam logic [7:0] OFF_DISPLAY  = 8'h18;
    localparam logic [7:0] OFF_STATUS   = 8'h1c;
    localparam logic [7:0] OFF_MASK     = 8'h20;
    localparam logic [7:0] OFF_MENU     = 8'h24;

    // Input types
    localparam logic [1:0] count_up_input_type     = 2'h0;
    localparam logic [1:0] count_down_input_type   = 2'h1;
    localparam logic [1:0] bus_display_input_type  = 2'h2;

    // Conditioning selections
    localparam logic [1:0] COND_LOGIC              = 2'h0;
    localparam logic [1:0] sinking_contact_input   = 2'h1;
    localparam logic [1:0] sourcing_contact_input  = 2'h2;

    // Range limit modes
    localparam logic [1:0] LIMIT_OFF               = 2'h0;
    localparam logic [1:0] limit_error_mode        = 2'h1;
    localparam logic [1:0] limit_clamp_mode        = 2'h2;

    // Status bit positions
    localparam int ST_OVER    = 0;
    localparam int ST_UNDER   = 1;
    localparam int ST_BUSVAL  = 2;
    localparam int ST_SYSINIT = 3;
    localparam int ST_MAXRNG  = 4;
    localparam int ST_W       = 5;

    // Menu control bits
    localparam int MENU_STEP_BIT    = 0;
    localparam int MENU_RESTART_BIT = 1;

    // Reset values and address limit
    localparam logic [15:0] PRESCALE_RST = 16'h0001;
    localparam logic [15:0] DISP_HI_RST  = 16'h03e8;
    localparam logic [7:0]  ADDR_MAX     = 8'hef;
    localparam logic [7:0]  ADDR_DEF     = 8'h01;

    typedef struct packed {
        logic [2:0] decimal_point_pos;
        logic [1:0] range_limit_mode;
        logic       falling_edge_sel;
        logic [1:0] input_conditioning_select;
        logic [1:0] input_type;
    } pcd_ctrl_t;

    localparam pcd_ctrl_t CTRL_RST = '0;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
    } pcd_addr_wr_t;

    typedef enum logic [7:0] {
        M_INPUT  = 8'h01,
        M_EDGE   = 8'h02,
        M_PRESC  = 8'h04,
        M_UPPER  = 8'h08,
        M_DP     = 8'h10,
        M_DISPHI = 8'h20,
        M_LIMIT  = 8'h40,
        M_OUTPUT = 8'h80
    } pcd_menu_t;

endpackage

// >>> pcd_prescale.sv
module pcd_prescale #(
    parameter int DIV_W = 16
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    // Pulse pin and control
    input  wire logic             pulse_pin,
    input  wire logic             falling_edge_sel,
    input  wire logic             run,
    input  wire logic             clear,
    input  wire logic [DIV_W-1:0] divisor,
    // Forwarded pulse
    output logic                  tick
);
    logic             sync1;
    logic             sync2;
    logic             prev;
    logic [DIV_W-1:0] acc;

    wire logic             rise      = sync2 & ~prev;
    wire logic             fall      = ~sync2 & prev;
    wire logic             edge_hit  = falling_edge_sel ? fall : rise;
    // Divisor zero behaves as one
    wire logic [DIV_W-1:0] last      = (divisor == '0) ? '0 : divisor - 1'b1;
    wire logic             wrap      = run & edge_hit & (acc == last);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev  <= 1'b0;
        end else if (ce) begin
            sync1 <= pulse_pin;
            sync2 <= sync1;
            prev  <= sync2;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc  <= '0;
            tick <= 1'b0;
        end else if (ce) begin
            tick <= wrap;
            if (clear)
                acc <= '0;
            else if (wrap)
                acc <= '0;
            else if (run && edge_hit)
                acc <= acc + 1'b1;
        end
    end

    chk_tick_needs_edge: assert property (@(posedge pclk) disable iff (!presetn)
        ce && tick |-> $past(edge_hit) && $past(run)) else $error("tick without edge");
endmodule

// >>> pcd_top.sv
module pcd_top #(
    parameter int CNT_W  = 20,
    parameter int DISP_W = 16,
    parameter int DIV_W  = 16
) (
    // Clock, reset, enable
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Pulse transmitter pins
    input  wire logic              pulse_pin,
    input  wire logic              cnt_rst_n_pin,
    output logic                   pullup_en,
    output logic                   pulldown_en,
    // Non-volatile count store
    input  wire logic              nv_load,
    input  wire logic [CNT_W-1:0]  nv_value,
    output logic                   nv_store,
    output logic [CNT_W-1:0]       nv_data,
    // Serial bus side
    input  wire logic              bus_val_wr,
    input  wire logic [DISP_W-1:0] bus_val_data,
    input  wire pcd_pkg::pcd_addr_wr_t bus_addr_wr,
    input  wire logic              bus_sysinit,
    output logic [7:0]             bus_addr,
    // Displayed value, also feeds switching
    output logic [DISP_W-1:0]      disp_value,
    output logic [2:0]             disp_dp,
    output logic                   disp_err,
    // Interrupt
    output logic                   irq
);
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    pcd_pkg::pcd_ctrl_t             ctrl;
    logic [DIV_W-1:0]               prescale;
    logic [CNT_W-1:0]               upper;
    logic [DISP_W-1:0]              disp_hi;
    logic [DISP_W-1:0]              bus_value;
    logic [CNT_W-1:0]               count;
    logic                           under;
    logic [pcd_pkg::ST_W-1:0]       status;
    logic [pcd_pkg::ST_W-1:0]       mask;
    pcd_pkg::pcd_menu_t             menu;
    pcd_pkg::pcd_menu_t             next_menu;
    logic                           rst_s1;
    logic                           rst_s2;
    logic                           tick;

    // APB decode
    wire logic setup    = psel & ~penable;
    wire logic wr_acc   = ce & psel & penable & pwrite;
    wire logic hit_ctrl = paddr == pcd_pkg::OFF_CTRL;
    wire logic hit_pre  = paddr == pcd_pkg::OFF_PRESCALE;
    wire logic hit_up   = paddr == pcd_pkg::OFF_UPPER;
    wire logic hit_dhi  = paddr == pcd_pkg::OFF_DISP_HI;
    wire logic hit_addr = paddr == pcd_pkg::OFF_ADDR;
    wire logic hit_cnt  = paddr == pcd_pkg::OFF_COUNT;
    wire logic hit_disp = paddr == pcd_pkg::OFF_DISPLAY;
    wire logic hit_st   = paddr == pcd_pkg::OFF_STATUS;
    wire logic hit_mask = paddr == pcd_pkg::OFF_MASK;
    wire logic hit_menu = paddr == pcd_pkg::OFF_MENU;
    wire logic mapped   = hit_ctrl | hit_pre | hit_up | hit_dhi | hit_addr | hit_cnt
                        | hit_disp | hit_st | hit_mask | hit_menu;

    assign pready  = ce;
    assign pslverr = psel & penable & ~mapped;

    // Mode decode
    wire logic bus_mode  = ctrl.input_type == pcd_pkg::bus_display_input_type;
    wire logic down_mode = ctrl.input_type == pcd_pkg::count_down_input_type;
    wire logic hold      = ~rst_s2;
    wire logic [CNT_W-1:0] start_val = down_mode ? upper : '0;

    // Conditioning drives the pin resistors
    assign pullup_en   = ctrl.input_conditioning_select == pcd_pkg::sinking_contact_input;
    assign pulldown_en = ctrl.input_conditioning_select == pcd_pkg::sourcing_contact_input;

    pcd_prescale #(
        .DIV_W (DIV_W)
    ) u_pre (
        .pclk             (pclk),
        .presetn          (presetn),
        .ce               (ce),
        .pulse_pin        (pulse_pin),
        .falling_edge_sel (ctrl.falling_edge_sel),
        .run              (~bus_mode & ~hold),
        .clear            (hold),
        .divisor          (prescale),
        .tick             (tick)
    );

    // Counter next value
    wire logic up_step   = tick & ~down_mode & ~hold & ~nv_load;
    wire logic dn_step   = tick & down_mode & ~hold & ~nv_load;
    wire logic ev_under  = dn_step & (count == '0);
    wire logic ev_over   = up_step & (count == upper);
    wire logic ev_maxrng = up_step & (count == CNT_MAX - 1'b1);
    logic [CNT_W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (nv_load)
            next_count = nv_value;
        else if (hold)
            next_count = start_val;
        else if (up_step && count != CNT_MAX)
            next_count = count + 1'b1;
        else if (dn_step && count != '0)
            next_count = count - 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_s1 <= 1'b1;
            rst_s2 <= 1'b1;
        end else if (ce) begin
            rst_s1 <= cnt_rst_n_pin;
            rst_s2 <= rst_s1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count    <= '0;
            under    <= 1'b0;
            nv_store <= 1'b0;
            nv_data  <= '0;
        end else if (ce) begin
            count    <= next_count;
            nv_store <= next_count != count;
            nv_data  <= next_count;
            if (hold || nv_load)
                under <= 1'b0;
            else if (ev_under)
                under <= 1'b1;
        end
    end

    // Scaling onto the display range
    wire logic [CNT_W+DISP_W-1:0] product = count * disp_hi;
    wire logic [CNT_W+DISP_W-1:0] quot    = (upper == '0) ? '0 : product / upper;
    wire logic [DISP_W-1:0]       scaled  = quot[DISP_W-1:0];
    wire logic                    over    = count > upper;
    wire logic                    at_max  = count == CNT_MAX;
    logic [DISP_W-1:0]            next_disp;
    logic                         next_err;

    always_comb begin
        next_disp = scaled;
        next_err  = at_max;
        if (bus_mode) begin
            next_disp = bus_value;
            next_err  = 1'b0;
        end else if (ctrl.range_limit_mode == pcd_pkg::limit_error_mode) begin
            next_err  = over | under | at_max;
        end else if (ctrl.range_limit_mode == pcd_pkg::limit_clamp_mode) begin
            if (over)
                next_disp = disp_hi;
            else if (under)
                next_disp = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_value <= '0;
            disp_dp    <= '0;
            disp_err   <= 1'b0;
        end else if (ce) begin
            disp_value <= next_disp;
            disp_dp    <= ctrl.decimal_point_pos;
            disp_err   <= next_err;
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl     <= pcd_pkg::CTRL_RST;
            prescale <= pcd_pkg::PRESCALE_RST;
            upper    <= '1;
            disp_hi  <= pcd_pkg::DISP_HI_RST;
            mask     <= '0;
        end else if (wr_acc) begin
            if (hit_ctrl)
                ctrl <= pwdata[$bits(pcd_pkg::pcd_ctrl_t)-1:0];
            if (hit_pre)
                prescale <= pwdata[DIV_W-1:0];
            if (hit_up)
                upper <= pwdata[CNT_W-1:0];
            if (hit_dhi)
                disp_hi <= pwdata[DISP_W-1:0];
            if (hit_mask)
                mask <= pwdata[pcd_pkg::ST_W-1:0];
        end
    end

    // Bus address: init wins, then bus master, then software
    wire logic apb_addr_ok = wr_acc & hit_addr & (pwdata[7:0] <= pcd_pkg::ADDR_MAX);
    wire logic bus_addr_ok = bus_addr_wr.valid & (bus_addr_wr.addr <= pcd_pkg::ADDR_MAX);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_addr  <= pcd_pkg::ADDR_DEF;
            bus_value <= '0;
        end else if (ce) begin
            if (bus_sysinit)
                bus_addr <= pcd_pkg::ADDR_DEF;
            else if (bus_addr_ok)
                bus_addr <= bus_addr_wr.addr;
            else if (apb_addr_ok)
                bus_addr <= pwdata[7:0];
            if (bus_val_wr)
                bus_value <= bus_val_data;
        end
    end

    // Status, set wins over a same-cycle clear
    wire logic [pcd_pkg::ST_W-1:0] ev_set = {ev_maxrng, bus_sysinit, bus_val_wr,
                                             ev_under, ev_over};
    wire logic [pcd_pkg::ST_W-1:0] w1c    = (wr_acc & hit_st) ? pwdata[pcd_pkg::ST_W-1:0]
                                                               : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            status <= '0;
        else if (ce)
            status <= (status & ~w1c) | ev_set;
    end

    assign irq = |(status & mask);

    // Configuration menu sequence
    always_comb begin
        unique case (menu)
            pcd_pkg::M_INPUT:  next_menu = bus_mode ? pcd_pkg::M_OUTPUT : pcd_pkg::M_EDGE;
            pcd_pkg::M_EDGE:   next_menu = pcd_pkg::M_PRESC;
            pcd_pkg::M_PRESC:  next_menu = pcd_pkg::M_UPPER;
            pcd_pkg::M_UPPER:  next_menu = pcd_pkg::M_DP;
            pcd_pkg::M_DP:     next_menu = pcd_pkg::M_DISPHI;
            pcd_pkg::M_DISPHI: next_menu = pcd_pkg::M_LIMIT;
            pcd_pkg::M_LIMIT:  next_menu = pcd_pkg::M_OUTPUT;
            pcd_pkg::M_OUTPUT: next_menu = pcd_pkg::M_OUTPUT;
            default:           next_menu = pcd_pkg::M_INPUT;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            menu <= pcd_pkg::M_INPUT;
        else if (wr_acc && hit_menu) begin
            if (pwdata[pcd_pkg::MENU_RESTART_BIT])
                menu <= pcd_pkg::M_INPUT;
            else if (pwdata[pcd_pkg::MENU_STEP_BIT])
                menu <= next_menu;
        end
    end

    // Read data captured in setup so it is stable in access
    wire logic [31:0] rd_mux =
        hit_ctrl ? 32'(ctrl) :
        hit_pre  ? 32'(prescale) :
        hit_up   ? 32'(upper) :
        hit_dhi  ? 32'(disp_hi) :
        hit_addr ? 32'(bus_addr) :
        hit_cnt  ? 32'(count) :
        hit_disp ? {12'h000, disp_err, disp_dp, disp_value} :
        hit_st   ? 32'(status) :
        hit_mask ? 32'(mask) :
        hit_menu ? 32'(menu) : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= '0;
        else if (ce && setup && !pwrite)
            prdata <= rd_mux;
    end

    chk_hold_start: assert property (@(posedge pclk) disable iff (!presetn)
        ce && hold && !nv_load |=> count == $past(start_val))
        else $error("count not held at start");
    chk_up_step: assert property (@(posedge pclk) disable iff (!presetn)
        ce && up_step && count != CNT_MAX |=> count == $past(count) + 1'b1)
        else $error("up count did not increment");
    chk_down_step: assert property (@(posedge pclk) disable iff (!presetn)
        ce && dn_step && count != '0 |=> count == $past(count) - 1'b1)
        else $error("down count did not decrement");
    chk_addr_range: assert property (@(posedge pclk) disable iff (!presetn)
        bus_addr <= pcd_pkg::ADDR_MAX)
        else $error("address out of range");
    chk_sysinit_addr: assert property (@(posedge pclk) disable iff (!presetn)
        ce && bus_sysinit |=> bus_addr == pcd_pkg::ADDR_DEF)
        else $error("address not reset by init");
    chk_bus_display: assert property (@(posedge pclk) disable iff (!presetn)
        ce && bus_mode |=> disp_value == $past(bus_value) && !disp_err)
        else $error("bus value not displayed");
    chk_error_show: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !bus_mode && ctrl.range_limit_mode == pcd_pkg::limit_error_mode
        && (over || under) |=> disp_err)
        else $error("error not shown");
    chk_clamp_high: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !bus_mode && ctrl.range_limit_mode == pcd_pkg::limit_clamp_mode
        && over |=> disp_value == $past(disp_hi))
        else $error("clamp value wrong");
    chk_menu_order: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && hit_menu && pwdata[1:0] == 2'h1 && menu == pcd_pkg::M_EDGE
        |=> menu == pcd_pkg::M_PRESC)
        else $error("menu order broken");
    chk_nv_mirror: assert property (@(posedge pclk) disable iff (!presetn)
        ce && nv_store |-> nv_data == count && count != $past(count))
        else $error("nv store mismatch");
endmodule

// >>> pcd_xmit.sv
module pcd_xmit (
    // Clock
    input  wire logic              pclk,
    // Pulse transmitter pins
    output logic                   pulse_pin,
    output logic                   cnt_rst_n_pin,
    // Serial bus master
    output logic                   bus_val_wr,
    output logic [15:0]            bus_val_data,
    output pcd_pkg::pcd_addr_wr_t  bus_addr_wr,
    output logic                   bus_sysinit
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        pulse_pin = 1'b0;
        cnt_rst_n_pin = 1'b1;
        bus_val_wr = 1'b0;
        bus_val_data = 16'h0000;
        bus_addr_wr = '0;
        bus_sysinit = 1'b0;
    end

    // Four cycles high, five low between pulses, above the three the sampler needs
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge pclk) pulse_pin <= 1'b1;
            repeat (4) @(posedge pclk);
            pulse_pin <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask

    task automatic hold_reset();
        @(posedge pclk) cnt_rst_n_pin <= 1'b0;
        repeat (6) @(posedge pclk);
        cnt_rst_n_pin <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask

    // Data lines flip once released so a stale value never looks valid
    task automatic send_val(input logic [15:0] v);
        @(posedge pclk) bus_val_wr <= 1'b1;
        bus_val_data <= v;
        @(posedge pclk) bus_val_wr <= 1'b0;
        bus_val_data <= ~v;
    endtask

    task automatic send_addr(input logic [7:0] a);
        @(posedge pclk) bus_addr_wr <= '{valid: 1'b1, addr: a};
        @(posedge pclk) bus_addr_wr <= '{valid: 1'b0, addr: ~a};
    endtask

    task automatic sysinit();
        @(posedge pclk) bus_sysinit <= 1'b1;
        @(posedge pclk) bus_sysinit <= 1'b0;
    endtask
endmodule

// >>> pulse_counter_display_mode_test.sv
module pulse_counter_display_mode_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0]  paddr, bus_addr;
    logic [31:0] pwdata, prdata, rdata;
    logic        pulse_pin, cnt_rst_n_pin, pullup_en, pulldown_en, nv_load;
    logic [19:0] nv_value, nv_data;
    logic        bus_val_wr, bus_sysinit, disp_err, irq, nv_store;
    logic [15:0] bus_val_data, disp_value;
    logic [2:0]  disp_dp;
    pcd_pkg::pcd_addr_wr_t bus_addr_wr;
    int          n_mismatch, compares, cycles;

    pcd_top u_pcd_top (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pulse_pin(pulse_pin),
        .cnt_rst_n_pin(cnt_rst_n_pin), .pullup_en(pullup_en),
        .pulldown_en(pulldown_en), .nv_load(nv_load), .nv_value(nv_value),
        .nv_store(nv_store), .nv_data(nv_data), .bus_val_wr(bus_val_wr),
        .bus_val_data(bus_val_data), .bus_addr_wr(bus_addr_wr),
        .bus_sysinit(bus_sysinit), .bus_addr(bus_addr), .disp_value(disp_value),
        .disp_dp(disp_dp), .disp_err(disp_err), .irq(irq)
    );

    pcd_xmit u_pcd_xmit (
        .pclk(pclk), .pulse_pin(pulse_pin), .cnt_rst_n_pin(cnt_rst_n_pin),
        .bus_val_wr(bus_val_wr), .bus_val_data(bus_val_data),
        .bus_addr_wr(bus_addr_wr), .bus_sysinit(bus_sysinit)
    );

    always #2 pclk = ~pclk;

    task automatic print_verdict();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Generous ceiling; the whole sequence needs well under a tenth of it
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (2) @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdata, e);
    endtask

    task automatic t_reset();
        rd(pcd_pkg::OFF_PRESCALE, 32'h1);
        rd(pcd_pkg::OFF_DISP_HI, 32'h3e8);
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(rerr), 32'h1);
        @(posedge pclk) nv_load <= 1'b1;
        @(posedge pclk) nv_load <= 1'b0;
        // Store strobe stands one cycle only
        @(negedge pclk);
        chk(32'(nv_store), 32'h1);
        chk(32'(nv_data), 32'h7);
        rd(pcd_pkg::OFF_COUNT, 32'h7);
        u_pcd_xmit.hold_reset();
        rd(pcd_pkg::OFF_COUNT, 32'h0);
    endtask

    task automatic t_menu();
        for (int i = 0; i < 8; i++) begin
            rd(pcd_pkg::OFF_MENU, 32'h1 << i);
            wr(pcd_pkg::OFF_MENU, 32'h1);
        end
        wr(pcd_pkg::OFF_MENU, 32'h2);
    endtask

    task automatic t_count();
        wr(pcd_pkg::OFF_PRESCALE, 32'h2);
        u_pcd_xmit.pulses(4);
        rd(pcd_pkg::OFF_COUNT, 32'h2);
        wr(pcd_pkg::OFF_CTRL, 32'h10);
        u_pcd_xmit.pulses(2);
        rd(pcd_pkg::OFF_COUNT, 32'h3);
        u_pcd_xmit.pulses(1);
        u_pcd_xmit.hold_reset();
        u_pcd_xmit.pulses(1);
        rd(pcd_pkg::OFF_COUNT, 32'h0);
        u_pcd_xmit.pulses(1);
        rd(pcd_pkg::OFF_COUNT, 32'h1);
    endtask

    task automatic t_down();
        wr(pcd_pkg::OFF_PRESCALE, 32'h1);
        wr(pcd_pkg::OFF_UPPER, 32'h3);
        wr(pcd_pkg::OFF_CTRL, 32'h1);
        u_pcd_xmit.hold_reset();
        rd(pcd_pkg::OFF_COUNT, 32'h3);
        u_pcd_xmit.pulses(1);
        rd(pcd_pkg::OFF_COUNT, 32'h2);
        u_pcd_xmit.pulses(3);
        wr(pcd_pkg::OFF_CTRL, 32'h21);
        chk(32'(disp_err), 32'h1);
        rd(pcd_pkg::OFF_COUNT, 32'h0);
    endtask

    task automatic t_limits();
        wr(pcd_pkg::OFF_CTRL, 32'h40);
        wr(pcd_pkg::OFF_UPPER, 32'h2);
        wr(pcd_pkg::OFF_DISP_HI, 32'h64);
        wr(pcd_pkg::OFF_MASK, 32'h1);
        u_pcd_xmit.hold_reset();
        u_pcd_xmit.pulses(1);
        chk(32'(disp_value), 32'h32);
        u_pcd_xmit.pulses(2);
        chk(32'(disp_value), 32'h64);
        chk(32'(irq), 32'h1);
        wr(pcd_pkg::OFF_CTRL, 32'h20);
        chk(32'(disp_err), 32'h1);
        wr(pcd_pkg::OFF_CTRL, 32'h0);
        chk(32'(disp_err), 32'h0);
        rd(pcd_pkg::OFF_COUNT, 32'h3);
        u_pcd_xmit.hold_reset();
        wr(pcd_pkg::OFF_STATUS, 32'h1f);
        chk(32'(irq), 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr(pcd_pkg::OFF_CTRL, 32'(i) << 2);
            chk({30'h0, pulldown_en, pullup_en}, 32'(i));
        end
    endtask

    task automatic t_bus();
        wr(pcd_pkg::OFF_CTRL, 32'h2);
        wr(pcd_pkg::OFF_MENU, 32'h1);
        rd(pcd_pkg::OFF_MENU, 32'h80);
        wr(pcd_pkg::OFF_MENU, 32'h2);
        u_pcd_xmit.send_val(16'h1234);
        repeat (3) @(posedge pclk);
        chk(32'(disp_value), 32'h1234);
        u_pcd_xmit.pulses(2);
        rd(pcd_pkg::OFF_COUNT, 32'h0);
        u_pcd_xmit.send_addr(8'hf0);
        repeat (2) @(posedge pclk);
        chk(32'(bus_addr), 32'h1);
        u_pcd_xmit.send_addr(8'hef);
        repeat (2) @(posedge pclk);
        chk(32'(bus_addr), 32'hef);
        wr(pcd_pkg::OFF_ADDR, 32'h5);
        chk(32'(bus_addr), 32'h5);
        u_pcd_xmit.sysinit();
        repeat (2) @(posedge pclk);
        chk(32'(bus_addr), 32'h1);
    endtask

    // Enable low must swallow both a load and pin edges
    task automatic t_freeze();
        wr(pcd_pkg::OFF_CTRL, 32'h180);
        chk(32'(disp_dp), 32'h3);
        @(posedge pclk) ce <= 1'b0;
        nv_load <= 1'b1;
        nv_value <= 20'h00009;
        u_pcd_xmit.pulses(2);
        chk(32'(pready), 32'h0);
        @(posedge pclk) ce <= 1'b1;
        nv_load <= 1'b0;
        rd(pcd_pkg::OFF_COUNT, 32'h0);
        @(posedge pclk) nv_load <= 1'b1;
        @(posedge pclk) nv_load <= 1'b0;
        @(negedge pclk);
        chk(32'(nv_data), 32'h9);
        u_pcd_xmit.pulses(1);
        rd(pcd_pkg::OFF_COUNT, 32'ha);
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        nv_load = 1'b0;
        nv_value = 20'h00007;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_menu();
        t_count();
        t_down();
        t_limits();
        t_bus();
        t_freeze();
        print_verdict();
    end
endmodule
